// ---- design/arta_edge_det.sv ----
// Selectable-polarity edge detector for one capture input.
// Assumes the pin is already synchronous to core_clk.
`default_nettype none
module arta_edge_det (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pinIn,
  input wire logic risingSel,
  input wire logic enable,
  output logic edgePulse
);
  logic prev;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= pinIn;
    end
  end

  // Disabled while stopped so a stale level cannot fake an edge at start
  always_comb begin
    edgePulse = enable & (risingSel ? (pinIn & ~prev) : (~pinIn & prev));
  end
endmodule : arta_edge_det
`default_nettype wire

// ---- design/arta_pkg.sv ----
// Package for the auto-reload timer control block: register indices,
// field positions, access masks, reset values and shared types.
// Assumes an APB slave with byte address = four times the register index.
`default_nettype none
package arta_pkg;
  localparam int ADDR_W = 12;
  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_MASK_LO = 8'hE0;
  localparam logic [7:0] IDX_CAP1_CTRL = 8'hE1;
  localparam logic [7:0] IDX_CAP2_CTRL = 8'hE2;
  localparam logic [7:0] IDX_OUT_CTRL = 8'hE3;
  localparam logic [7:0] IDX_TIMER_CTRL = 8'hE8;
  localparam logic [7:0] IDX_RLD_HI = 8'hE9;
  localparam logic [7:0] IDX_RLD_LO = 8'hEA;
  localparam logic [7:0] IDX_CAP_HI = 8'hEB;
  localparam logic [7:0] IDX_CAP_LO = 8'hEC;
  localparam logic [7:0] IDX_CMP_HI = 8'hED;
  localparam logic [7:0] IDX_CMP_LO = 8'hEE;
  localparam logic [7:0] IDX_MASK_HI = 8'hEF;
  // timer control fields
  localparam int T_PSC_LO = 6;
  localparam int T_RELOAD = 5;
  localparam int T_RUN = 4;
  localparam int T_OVF_IEN = 3;
  localparam int T_OVF_FLG = 2;
  localparam int T_OVF_MODE = 1;
  // capture_one_status_control fields
  localparam int C1_ERR1 = 6;
  localparam int C1_ERR2 = 5;
  localparam int C1_IEN = 4;
  localparam int C1_FLG = 3;
  localparam int C1_POL = 2;
  localparam int C1_RSEL_LO = 0;
  // capture_two_compare_status_control fields
  localparam int C2_POL = 7;
  localparam int C2_IEN = 6;
  localparam int C2_FLG = 5;
  localparam int C2_CMP_IEN = 4;
  localparam int C2_CMP_FLG = 3;
  localparam int C2_ZERO_IEN = 2;
  localparam int C2_ZERO_FLG = 1;
  localparam int C2_WAVE_MODE = 0;
  // output_pin_control fields
  localparam int O_OVF_POL = 3;
  localparam int O_OVF_EN = 2;
  localparam int O_WAVE_POL = 1;
  localparam int O_WAVE_EN = 0;
  // Plain read/write bits and write-zero-to-clear flags per register
  localparam logic [7:0] TIMER_RW_MASK = 8'hFA;
  localparam logic [7:0] TIMER_FLG_MASK = 8'h04;
  localparam logic [7:0] CAP1_RW_MASK = 8'h17;
  localparam logic [7:0] CAP1_FLG_MASK = 8'h68;
  localparam logic [7:0] CAP2_RW_MASK = 8'hD5;
  localparam logic [7:0] CAP2_FLG_MASK = 8'h2A;
  localparam logic [7:0] OUT_RW_MASK = 8'h0F;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  typedef enum logic [1:0] {
    RLD_BY_RUN = 2'b00,
    RLD_BY_CAP1 = 2'b01,
    RLD_BY_CAP2 = 2'b10,
    RLD_OFF = 2'b11
  } arta_rld_src_t;
  typedef struct packed {
    logic wrHi;
    logic wrLo;
    logic [7:0] data;
  } arta_byte_wr_t;
endpackage : arta_pkg
`default_nettype wire

// ---- design/arta_timer_ctrl.sv ----
// Control, status, capture and output logic of a 16-bit auto-reload timer.
// Assumes an external down counter supplying its value and overflow pulse;
// capture pins are synchronous to core_clk; APB with no wait states.
//
// Notes on behaviour
// - Extra first-input event while its flag is set raises first error; clear only
// - First error set blocks further first-input events; clear both together
// - Extra second-input event while its flag is set raises second error
// - Second error set blocks further second-input events
// - First-input event sets first flag until cleared; writing one never sets
// - First second-input event sets second flag and captures the counter
// - First polarity bit: zero falling edge, one rising edge
// - Second polarity bit: zero falling edge, one rising edge
// - Reload source: run bit, first input, second input, or none
// - Masked compare: counter and mask equals compare and mask
// - Masked zero: counter and mask equals zero
// - Compare flag set on masked compare; software only clears it
// - Zero flag set on masked zero only while running
// - Each flag reaches the interrupt only with its enable set
// - Wave output: set on zero, reset on compare; toggle mode on compare
// - Wave polarity one inverts set and reset; idle level one
// - Wave enable zero holds output at its polarity level
// - Overflow polarity zero sets on overflow; one resets; idle at polarity
// - Overflow enable zero holds output at its polarity level
// - High byte writes go to a latch; low byte write loads both
// - High byte reads return the register, not the latch
// - Reload word writable only with reload enabled; capture word read only
// - Overflow set mode follows flag; toggle mode toggles each overflow
// - Reload disabled makes reload word a capture target on first input
`default_nettype none
module arta_timer_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [arta_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] downCounter,
  input wire logic counterOverflow,
  input wire logic firstCaptureInput,
  input wire logic secondCaptureInput,
  output logic [1:0] prescaleSel,
  output logic runOrClearCounter,
  output logic reloadEnable,
  output logic reloadStrobe,
  output logic [15:0] reloadValue,
  output logic timerIrq,
  output logic waveOut,
  output logic overflowOutPin
);
  logic [7:0] timerCtrl, capOneCtrl, capTwoCtrl, outCtrl;
  logic [7:0] next_timerCtrl, next_capOneCtrl, next_capTwoCtrl, next_outCtrl;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_reloadStrobe, next_timerIrq;
  logic next_waveOut, next_overflowOutPin;
  logic waveState, next_waveState, ovfToggle, next_ovfToggle;
  logic cmpPrev, zeroPrev;
  logic [7:0] regIdx;
  logic mapped, doWrite;
  logic [1:0] capEdge;
  logic [1:0] capPin;
  logic [1:0] capPol;
  logic cap1Ev, cap2Ev, cmpMatch, zeroMatch, cmpEv, zeroEv, runRise;
  logic [15:0] rlcpWord, cpWord, cmpWord, maskWord;
  arta_pkg::arta_byte_wr_t rlcpWr, cpWr, cmpWr, maskWr;
  arta_pkg::arta_rld_src_t rldSrc;

  assign prescaleSel = timerCtrl[arta_pkg::T_PSC_LO +: 2];
  assign runOrClearCounter = timerCtrl[arta_pkg::T_RUN];
  assign reloadEnable = timerCtrl[arta_pkg::T_RELOAD];
  assign reloadValue = rlcpWord;
  assign rldSrc = arta_pkg::arta_rld_src_t'(capOneCtrl[arta_pkg::C1_RSEL_LO +: 2]);

  // Address decode; only word-aligned indices in the map answer cleanly
  always_comb begin
    regIdx = paddr[9:2];
    mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
      (((regIdx >= arta_pkg::IDX_MASK_LO) && (regIdx <= arta_pkg::IDX_OUT_CTRL)) ||
       ((regIdx >= arta_pkg::IDX_TIMER_CTRL) && (regIdx <= arta_pkg::IDX_MASK_HI)));
    doWrite = psel & penable & pready & pwrite & mapped;
  end

  // Capture inputs run only while the counter is enabled
  assign capPin = {secondCaptureInput, firstCaptureInput};
  assign capPol = {capTwoCtrl[arta_pkg::C2_POL], capOneCtrl[arta_pkg::C1_POL]};
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gCapEdge
      arta_edge_det uEdge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn(capPin[ch]),
        .risingSel(capPol[ch]),
        .enable(timerCtrl[arta_pkg::T_RUN]),
        .edgePulse(capEdge[ch])
      );
    end
  endgenerate

  always_comb begin
    cap1Ev = capEdge[0] & ~capOneCtrl[arta_pkg::C1_ERR1];
    cap2Ev = capEdge[1] & ~capOneCtrl[arta_pkg::C1_ERR2];
    cmpMatch = (downCounter & maskWord) == (cmpWord & maskWord);
    zeroMatch = (downCounter & maskWord) == arta_pkg::WORD_RESET;
    cmpEv = cmpMatch & ~cmpPrev;
    // A counter held clear by the run bit does not count as zero
    zeroEv = zeroMatch & ~zeroPrev & timerCtrl[arta_pkg::T_RUN];
    runRise = doWrite && (regIdx == arta_pkg::IDX_TIMER_CTRL) &&
      pwdata[arta_pkg::T_RUN] && !timerCtrl[arta_pkg::T_RUN];
  end

  // Byte write strobes for the 16-bit registers
  always_comb begin
    rlcpWr = '{wrHi: 1'b0, wrLo: 1'b0, data: pwdata[7:0]};
    cpWr = '{wrHi: 1'b0, wrLo: 1'b0, data: pwdata[7:0]};
    cmpWr = '{wrHi: 1'b0, wrLo: 1'b0, data: pwdata[7:0]};
    maskWr = '{wrHi: 1'b0, wrLo: 1'b0, data: pwdata[7:0]};
    if (doWrite) begin
      rlcpWr.wrHi = (regIdx == arta_pkg::IDX_RLD_HI) & reloadEnable;
      rlcpWr.wrLo = (regIdx == arta_pkg::IDX_RLD_LO) & reloadEnable;
      cmpWr.wrHi = regIdx == arta_pkg::IDX_CMP_HI;
      cmpWr.wrLo = regIdx == arta_pkg::IDX_CMP_LO;
      maskWr.wrHi = regIdx == arta_pkg::IDX_MASK_HI;
      maskWr.wrLo = regIdx == arta_pkg::IDX_MASK_LO;
    end
  end

  arta_word_reg uRlcp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr(rlcpWr),
    .hwLoad(cap1Ev & ~capOneCtrl[arta_pkg::C1_FLG] & ~reloadEnable),
    .hwValue(downCounter),
    .word(rlcpWord)
  );
  arta_word_reg uCp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr(cpWr),
    .hwLoad(cap2Ev & ~capTwoCtrl[arta_pkg::C2_FLG]),
    .hwValue(downCounter),
    .word(cpWord)
  );
  arta_word_reg uCmp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr(cmpWr),
    .hwLoad(1'b0),
    .hwValue(arta_pkg::WORD_RESET),
    .word(cmpWord)
  );
  arta_word_reg uMask (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr(maskWr),
    .hwLoad(1'b0),
    .hwValue(arta_pkg::WORD_RESET),
    .word(maskWord)
  );

  // Control and flag registers; hardware sets are applied after the
  // software clear so an event in the clearing cycle is kept
  always_comb begin
    next_timerCtrl = timerCtrl;
    next_capOneCtrl = capOneCtrl;
    next_capTwoCtrl = capTwoCtrl;
    next_outCtrl = outCtrl;
    if (doWrite) begin
      case (regIdx)
        arta_pkg::IDX_TIMER_CTRL: next_timerCtrl = (pwdata[7:0] & arta_pkg::TIMER_RW_MASK) |
          (timerCtrl & pwdata[7:0] & arta_pkg::TIMER_FLG_MASK);
        arta_pkg::IDX_CAP1_CTRL: next_capOneCtrl = (pwdata[7:0] & arta_pkg::CAP1_RW_MASK) |
          (capOneCtrl & pwdata[7:0] & arta_pkg::CAP1_FLG_MASK);
        arta_pkg::IDX_CAP2_CTRL: next_capTwoCtrl = (pwdata[7:0] & arta_pkg::CAP2_RW_MASK) |
          (capTwoCtrl & pwdata[7:0] & arta_pkg::CAP2_FLG_MASK);
        arta_pkg::IDX_OUT_CTRL: next_outCtrl = pwdata[7:0] & arta_pkg::OUT_RW_MASK;
        default: ;
      endcase
    end
    if (counterOverflow) begin
      next_timerCtrl[arta_pkg::T_OVF_FLG] = 1'b1;
    end
    if (cap1Ev) begin
      if (capOneCtrl[arta_pkg::C1_FLG]) begin
        next_capOneCtrl[arta_pkg::C1_ERR1] = 1'b1;
      end else begin
        next_capOneCtrl[arta_pkg::C1_FLG] = 1'b1;
      end
    end
    if (cap2Ev) begin
      if (capTwoCtrl[arta_pkg::C2_FLG]) begin
        next_capOneCtrl[arta_pkg::C1_ERR2] = 1'b1;
      end else begin
        next_capTwoCtrl[arta_pkg::C2_FLG] = 1'b1;
      end
    end
    if (cmpEv) begin
      next_capTwoCtrl[arta_pkg::C2_CMP_FLG] = 1'b1;
    end
    if (zeroEv) begin
      next_capTwoCtrl[arta_pkg::C2_ZERO_FLG] = 1'b1;
    end
  end

  // Reload trigger, interrupt and pins
  always_comb begin
    next_reloadStrobe = 1'b0;
    case (rldSrc)
      arta_pkg::RLD_BY_RUN: next_reloadStrobe = runRise;
      arta_pkg::RLD_BY_CAP1: next_reloadStrobe = cap1Ev;
      arta_pkg::RLD_BY_CAP2: next_reloadStrobe = cap2Ev;
      default: next_reloadStrobe = 1'b0;
    endcase
    next_reloadStrobe = next_reloadStrobe & reloadEnable;
    next_timerIrq =
      (capOneCtrl[arta_pkg::C1_FLG] & capOneCtrl[arta_pkg::C1_IEN]) |
      (capTwoCtrl[arta_pkg::C2_FLG] & capTwoCtrl[arta_pkg::C2_IEN]) |
      (timerCtrl[arta_pkg::T_OVF_FLG] & timerCtrl[arta_pkg::T_OVF_IEN]) |
      (capTwoCtrl[arta_pkg::C2_CMP_FLG] & capTwoCtrl[arta_pkg::C2_CMP_IEN]) |
      (capTwoCtrl[arta_pkg::C2_ZERO_FLG] & capTwoCtrl[arta_pkg::C2_ZERO_IEN]);
    next_waveState = waveState;
    if (capTwoCtrl[arta_pkg::C2_WAVE_MODE]) begin
      next_waveState = waveState ^ cmpEv;
    end else if (cmpEv) begin
      next_waveState = 1'b0;
    end else if (zeroEv) begin
      next_waveState = 1'b1;
    end
    // Polarity inverts the active level, so set and reset swap roles
    next_waveOut = outCtrl[arta_pkg::O_WAVE_POL] ^
      (outCtrl[arta_pkg::O_WAVE_EN] & next_waveState);
    next_ovfToggle = ovfToggle ^ counterOverflow;
    next_overflowOutPin = outCtrl[arta_pkg::O_OVF_POL] ^ (outCtrl[arta_pkg::O_OVF_EN] &
      (timerCtrl[arta_pkg::T_OVF_MODE] ? next_ovfToggle :
       next_timerCtrl[arta_pkg::T_OVF_FLG]));
  end

  // APB: read data latched in setup, answer one cycle later
  always_comb begin
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped;
    next_prdata = 32'h0000_0000;
    if (psel && !penable) begin
      case (regIdx)
        arta_pkg::IDX_TIMER_CTRL: next_prdata[7:0] = timerCtrl;
        arta_pkg::IDX_CAP1_CTRL: next_prdata[7:0] = capOneCtrl;
        arta_pkg::IDX_CAP2_CTRL: next_prdata[7:0] = capTwoCtrl;
        arta_pkg::IDX_OUT_CTRL: next_prdata[7:0] = outCtrl;
        arta_pkg::IDX_RLD_HI: next_prdata[7:0] = rlcpWord[15:8];
        arta_pkg::IDX_RLD_LO: next_prdata[7:0] = rlcpWord[7:0];
        arta_pkg::IDX_CAP_HI: next_prdata[7:0] = cpWord[15:8];
        arta_pkg::IDX_CAP_LO: next_prdata[7:0] = cpWord[7:0];
        arta_pkg::IDX_CMP_HI: next_prdata[7:0] = cmpWord[15:8];
        arta_pkg::IDX_CMP_LO: next_prdata[7:0] = cmpWord[7:0];
        arta_pkg::IDX_MASK_HI: next_prdata[7:0] = maskWord[15:8];
        arta_pkg::IDX_MASK_LO: next_prdata[7:0] = maskWord[7:0];
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerCtrl <= arta_pkg::BYTE_RESET;
      capOneCtrl <= arta_pkg::BYTE_RESET;
      capTwoCtrl <= arta_pkg::BYTE_RESET;
      outCtrl <= arta_pkg::BYTE_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      reloadStrobe <= 1'b0;
      timerIrq <= 1'b0;
      waveOut <= 1'b0;
      overflowOutPin <= 1'b0;
      waveState <= 1'b0;
      ovfToggle <= 1'b0;
      // Primed so a cleared counter after reset gives no compare event
      cmpPrev <= 1'b1;
      zeroPrev <= 1'b1;
    end else begin
      timerCtrl <= next_timerCtrl;
      capOneCtrl <= next_capOneCtrl;
      capTwoCtrl <= next_capTwoCtrl;
      outCtrl <= next_outCtrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      reloadStrobe <= next_reloadStrobe;
      timerIrq <= next_timerIrq;
      waveOut <= next_waveOut;
      overflowOutPin <= next_overflowOutPin;
      waveState <= next_waveState;
      ovfToggle <= next_ovfToggle;
      cmpPrev <= cmpMatch;
      zeroPrev <= zeroMatch;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_err1_on_repeat: assert property (cap1Ev && capOneCtrl[arta_pkg::C1_FLG] |=>
    capOneCtrl[arta_pkg::C1_ERR1]) else $error("first error not raised");
  a_err1_blocks_flag: assert property (capOneCtrl[arta_pkg::C1_ERR1] |=>
    !$rose(capOneCtrl[arta_pkg::C1_FLG])) else $error("first flag rose under error");
  a_err2_on_repeat: assert property (cap2Ev && capTwoCtrl[arta_pkg::C2_FLG] |=>
    capOneCtrl[arta_pkg::C1_ERR2]) else $error("second error not raised");
  a_err2_freezes_cap: assert property (capOneCtrl[arta_pkg::C1_ERR2] |=>
    $stable(cpWord)) else $error("capture taken under error");
  a_flag1_set: assert property (cap1Ev |=> capOneCtrl[arta_pkg::C1_FLG])
    else $error("first flag not set");
  a_cap2_value: assert property (cap2Ev && !capTwoCtrl[arta_pkg::C2_FLG] |=>
    capTwoCtrl[arta_pkg::C2_FLG] && cpWord == $past(downCounter))
    else $error("second capture wrong");
  a_reload_gated: assert property (!reloadEnable |=> !reloadStrobe)
    else $error("reload while disabled");
  a_cmp_flag_set: assert property (cmpEv |=> capTwoCtrl[arta_pkg::C2_CMP_FLG])
    else $error("compare flag not set");
  a_zero_when_stopped: assert property (!timerCtrl[arta_pkg::T_RUN] &&
    !capTwoCtrl[arta_pkg::C2_ZERO_FLG] |=> !capTwoCtrl[arta_pkg::C2_ZERO_FLG])
    else $error("zero flag set while cleared");
  a_irq_cap1: assert property (capOneCtrl[arta_pkg::C1_FLG] &&
    capOneCtrl[arta_pkg::C1_IEN] |=> timerIrq) else $error("irq missing");
  a_wave_idle: assert property (!outCtrl[arta_pkg::O_WAVE_EN] |=>
    waveOut == $past(outCtrl[arta_pkg::O_WAVE_POL])) else $error("wave not idle");
  a_ovf_idle: assert property (!outCtrl[arta_pkg::O_OVF_EN] |=>
    overflowOutPin == $past(outCtrl[arta_pkg::O_OVF_POL])) else $error("ovf not idle");
  a_rld_write_lock: assert property (!reloadEnable && !cap1Ev |=>
    $stable(rlcpWord)) else $error("reload word changed");

  c_err1_seen: cover property (cap1Ev && capOneCtrl[arta_pkg::C1_FLG]);
  c_cap2_taken: cover property (cap2Ev && !capTwoCtrl[arta_pkg::C2_FLG]);
  c_wave_toggle: cover property (outCtrl[arta_pkg::O_WAVE_EN] && $changed(waveOut));
  c_reload: cover property (reloadStrobe);
endmodule : arta_timer_ctrl
`default_nettype wire

// ---- design/arta_word_reg.sv ----
// 16-bit register written bytewise through a high-byte holding latch,
// with an optional hardware load that takes priority.
// Assumes high byte is written before low byte by software.
`default_nettype none
module arta_word_reg (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire arta_pkg::arta_byte_wr_t wr,
  input wire logic hwLoad,
  input wire logic [15:0] hwValue,
  output logic [15:0] word
);
  logic [7:0] hiLatch;
  logic [7:0] next_hiLatch;
  logic [15:0] next_word;

  always_comb begin
    next_hiLatch = wr.wrHi ? wr.data : hiLatch;
    next_word = word;
    if (hwLoad) begin
      next_word = hwValue;
    end else if (wr.wrLo) begin
      next_word = {hiLatch, wr.data};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hiLatch <= arta_pkg::BYTE_RESET;
      word <= arta_pkg::WORD_RESET;
    end else begin
      hiLatch <= next_hiLatch;
      word <= next_word;
    end
  end
endmodule : arta_word_reg
`default_nettype wire

// ---- tb/arta_pin_model.sv ----
// Far-side model: capture pins, counter value and overflow pulse.
// Assumes the bench calls its tasks; all changes follow a rising edge.
`default_nettype none
module arta_pin_model (
  input wire logic core_clk,
  output logic firstPin,
  output logic secondPin,
  output logic [15:0] count,
  output logic ovf
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    firstPin = 1'b0;
    secondPin = 1'b0;
    count = 16'h8001;
    ovf = 1'b0;
  end
  // Pins stay two cycles at each level, so no edge is lost
  task automatic pulse(input bit sec);
    repeat (2) @(posedge core_clk);
    if (sec) secondPin <= 1'b1; else firstPin <= 1'b1;
    repeat (2) @(posedge core_clk);
    if (sec) secondPin <= 1'b0; else firstPin <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse
  task automatic setCount(input logic [15:0] v);
    @(posedge core_clk);
    count <= v;
    repeat (3) @(posedge core_clk);
  endtask : setCount
  task automatic ovfPulse();
    @(posedge core_clk);
    ovf <= 1'b1;
    @(posedge core_clk);
    ovf <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : ovfPulse
endmodule : arta_pin_model
`default_nettype wire

// ---- tb/arta_timer_ctrl_tb.sv ----
// Bench for the timer control block: APB master, queue-checked reads.
// Assumes one APB slave and the pin model on the far side.
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module arta_timer_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, reloadStrobe, runOrClearCounter, reloadEnable;
  logic timerIrq, waveOut, overflowOutPin, fPin, sPin, ovf;
  logic [15:0] cnt, reloadValue, c1, c2, c3;
  logic [1:0] prescaleSel;
  logic [8:0] expQ[$];
  logic [8:0] expNext;
  int failures = 0, checks = 0, cyc = 0, strobes = 0;
  always #2 core_clk = ~core_clk;
  arta_pin_model u_pins (.core_clk(core_clk), .firstPin(fPin), .secondPin(sPin),
    .count(cnt), .ovf(ovf));
  arta_timer_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .downCounter(cnt),
    .counterOverflow(ovf), .firstCaptureInput(fPin), .secondCaptureInput(sPin),
    .prescaleSel(prescaleSel), .runOrClearCounter(runOrClearCounter),
    .reloadEnable(reloadEnable), .reloadStrobe(reloadStrobe),
    .reloadValue(reloadValue), .timerIrq(timerIrq), .waveOut(waveOut),
    .overflowOutPin(overflowOutPin));
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  // Read results: oldest expectation against {error, data}
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite) begin
      // Popped once here, since the macro names its arguments twice
      if (expQ.size() == 0) `CHK(1'b0, 1'b1)
      else begin
        expNext = expQ.pop_front();
        `CHK({pslverr, prdata[7:0]}, expNext)
      end
    end
  end
  // Strobe stands one cycle, so each pulse is counted once
  always @(posedge core_clk) begin
    if (reloadStrobe === 1'b1) strobes++;
  end
  task automatic xfer(input bit wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    if (!wr) expQ.push_back({1'b0, d});
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Waits only; the caller samples the pin afterwards, not at entry
  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask : settle
  initial begin
    void'($urandom(32'h8fbed257));
    rst_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'($urandom);
    pwdata <= $urandom;
    c1 = 16'h8000 | 16'($urandom);
    c2 = 16'h8000 | 16'($urandom);
    c3 = 16'h8000 | 16'($urandom);
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    xfer(0, 8'hE1, 8'h00);
    xfer(0, 8'hE2, 8'h00);
    xfer(0, 8'hE8, 8'h00);
    xfer(0, 8'hE3, 8'h00);
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= 12'h040;
    pwrite <= 1'b0;
    expQ.push_back(9'h100);
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    xfer(1, 8'hE8, 8'h10);
    u_pins.setCount(c1);
    xfer(1, 8'hE1, 8'h04);
    u_pins.pulse(0);
    xfer(0, 8'hE1, 8'h0C);
    xfer(0, 8'hE9, c1[15:8]);
    u_pins.setCount(c2);
    u_pins.pulse(0);
    xfer(0, 8'hE1, 8'h4C);
    xfer(1, 8'hE1, 8'h44);
    u_pins.pulse(0);
    xfer(0, 8'hE1, 8'h44);
    xfer(0, 8'hEA, c1[7:0]);
    xfer(1, 8'hE1, 8'h0C);
    xfer(0, 8'hE1, 8'h04);
    xfer(1, 8'hE1, 8'h14);
    u_pins.pulse(0);
    settle();
    `CHK(timerIrq, 1'b1)
    xfer(1, 8'hE1, 8'h0C);
    settle();
    `CHK(timerIrq, 1'b0)
    u_pins.setCount(c3);
    u_pins.pulse(1);
    xfer(0, 8'hE2, 8'h20);
    xfer(0, 8'hEB, c3[15:8]);
    u_pins.pulse(1);
    xfer(0, 8'hE1, 8'h2C);
    xfer(1, 8'hE2, 8'h00);
    u_pins.setCount(c1);
    u_pins.pulse(1);
    xfer(0, 8'hE2, 8'h00);
    xfer(1, 8'hEB, 8'h5A);
    xfer(0, 8'hEB, c3[15:8]);
    xfer(1, 8'hE9, 8'h12);
    xfer(1, 8'hEA, 8'h34);
    xfer(0, 8'hEA, c2[7:0]);
    xfer(1, 8'hE8, 8'h30);
    xfer(1, 8'hE9, 8'hA5);
    xfer(0, 8'hE9, c2[15:8]);
    xfer(1, 8'hEA, 8'h3C);
    xfer(0, 8'hE9, 8'hA5);
    `CHK(reloadValue, 16'hA53C)
    xfer(1, 8'hE3, 8'h0A);
    settle();
    `CHK(waveOut, 1'b1)
    `CHK(overflowOutPin, 1'b1)
    xfer(1, 8'hED, 8'h12);
    xfer(1, 8'hEE, 8'h34);
    xfer(1, 8'hE3, 8'h01);
    xfer(1, 8'hEF, 8'hFF);
    xfer(1, 8'hE0, 8'hFF);
    u_pins.setCount(16'h0000);
    `CHK(waveOut, 1'b1)
    u_pins.setCount(16'h1234);
    `CHK(waveOut, 1'b0)
    xfer(0, 8'hE2, 8'h0A);
    xfer(1, 8'hE3, 8'h04);
    u_pins.ovfPulse();
    `CHK(overflowOutPin, 1'b1)
    xfer(1, 8'hE8, 8'h30);
    settle();
    `CHK(overflowOutPin, 1'b0)
    // Reload by run bit rise, then by first-input event
    xfer(1, 8'hE1, 8'h00);
    xfer(1, 8'hE8, 8'h22);
    xfer(1, 8'hE8, 8'h32);
    xfer(1, 8'hE1, 8'h05);
    u_pins.pulse(0);
    `CHK(strobes, 2)
    `CHK({prescaleSel, reloadEnable, runOrClearCounter}, 4'b0011)
    // Overflow toggle mode: one overflow so far, so the pin toggles low
    u_pins.ovfPulse();
    `CHK(overflowOutPin, 1'b0)
    u_pins.ovfPulse();
    `CHK(overflowOutPin, 1'b1)
    // Wave toggle mode: zero ignored, compare toggles
    xfer(1, 8'hE2, 8'h01);
    xfer(1, 8'hE3, 8'h05);
    u_pins.setCount(16'h0000);
    `CHK(waveOut, 1'b0)
    u_pins.setCount(16'h1234);
    `CHK(waveOut, 1'b1)
    repeat (4) @(posedge core_clk);
    stop_test();
  end
endmodule : arta_timer_ctrl_tb
`undef CHK
`default_nettype wire
